// *** pkg/remote_i2c_alias_remap_pkg.sv ***
// constants for the remote target alias remapping block
`default_nettype none
package remote_i2c_alias_remap_pkg;
    localparam int NUM_ENTRIES = 7;
    localparam int ENTRY_W = 3;
    localparam int ADDR_W = 10;
    localparam int I2C_ADDR_W = 7;
    // register indices; byte address is four times the index
    localparam logic [7:0] TARGET_BASE_IDX = 8'h70;
    localparam logic [7:0] TARGET_6_IDX = 8'h75;
    localparam logic [7:0] TARGET_7_IDX = 8'h76;
    localparam logic [7:0] ALIAS_BASE_IDX = 8'h77;
    localparam logic [7:0] ALIAS_1_IDX = 8'h77;
    localparam logic [7:0] ALIAS_2_IDX = 8'h78;
    localparam logic [7:0] ALIAS_3_IDX = 8'h79;
    localparam logic [7:0] STATUS_IDX = 8'h7E;
    // field layout of the address registers
    localparam int ADDR_FIELD_LSB = 1;
    localparam int ADDR_FIELD_MSB = 7;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [6:0] ALIAS_DISABLED = 7'h00;
    // status register layout
    localparam int STAT_HIT_BIT = 0;
    localparam int STAT_ENTRY_LSB = 1;
    localparam int STAT_CNT_LSB = 4;
    localparam int STAT_CNT_W = 4;
endpackage
`default_nettype wire

// *** verilog/alias_match.sv ***
// one alias table entry compare
`default_nettype none
module alias_match
    import remote_i2c_alias_remap_pkg::*;
(
    input wire logic [I2C_ADDR_W-1:0] aliasAddr,
    input wire logic [I2C_ADDR_W-1:0] reqAddr,
    output logic hit
);
    // a zero alias never decodes, even for a zero request address
    assign hit = (aliasAddr != ALIAS_DISABLED) && (aliasAddr == reqAddr);
endmodule
`default_nettype wire

// *** verilog/remote_i2c_alias_remap.sv ***
// alias decode and remote target address remap with Avalon-MM registers
// Functional notes
// - target register bits 7:1 hold physical address
// - alias match replaces address with paired target
// - remapped transaction forwarded to control channel
// - alias register bits 7:1 hold decode address
// - alias N always pairs with target N
// - zero alias disables its entry
// - all alias and target registers reset zero
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`default_nettype none
module remote_i2c_alias_remap
    import remote_i2c_alias_remap_pkg::*;
#(
    parameter int ENTRIES = remote_i2c_alias_remap_pkg::NUM_ENTRIES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [remote_i2c_alias_remap_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic reqValid,
    input wire logic [remote_i2c_alias_remap_pkg::I2C_ADDR_W-1:0] reqAddr,
    input wire logic reqRnw,
    output logic fwdValid,
    output logic [remote_i2c_alias_remap_pkg::I2C_ADDR_W-1:0] fwdAddr,
    output logic fwdRnw,
    output logic [remote_i2c_alias_remap_pkg::ENTRY_W-1:0] fwdEntry,
    output logic missValid
);
    import remote_i2c_alias_remap_pkg::*;

    typedef struct packed {
        logic waitReq;
        logic [31:0] rdata;
        logic [ENTRIES-1:0][I2C_ADDR_W-1:0] target;
        logic [ENTRIES-1:0][I2C_ADDR_W-1:0] aliasAddr;
        logic fwdValid;
        logic [I2C_ADDR_W-1:0] fwdAddr;
        logic fwdRnw;
        logic [ENTRY_W-1:0] fwdEntry;
        logic missValid;
        logic lastHit;
        logic [ENTRY_W-1:0] lastEntry;
        logic [STAT_CNT_W-1:0] fwdCount;
    } state_t;

    localparam state_t STATE_RESET = '{waitReq: 1'b1, default: '0};

    state_t st_reg;
    state_t st_next;
    logic [7:0] regIdx;
    logic busReq;
    logic [ENTRIES-1:0] targetSel;
    logic [ENTRIES-1:0] aliasSel;
    logic [ENTRIES-1:0] entryHit;
    logic anyHit;
    logic [ENTRY_W-1:0] hitIdx;
    logic [31:0] readValue;

    assign regIdx = address[ADDR_W-1:2];
    assign busReq = read || write;

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++)
        begin : g_entry
            assign targetSel[g] = (address[1:0] == 2'h0) && (regIdx == TARGET_BASE_IDX + 8'(g));
            assign aliasSel[g] = (address[1:0] == 2'h0) && (regIdx == ALIAS_BASE_IDX + 8'(g));
            alias_match u_match (
                .aliasAddr(st_reg.aliasAddr[g]),
                .reqAddr(reqAddr),
                .hit(entryHit[g])
            );
        end
    endgenerate

    // lowest entry wins if software programs the same alias twice
    always_comb
    begin
        hitIdx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
            if (entryHit[i])
            begin
                hitIdx = ENTRY_W'(i);
            end
        end
    end
    assign anyHit = |entryHit;

    // unmapped and misaligned addresses read zero; bits above 7 are zero, and bit 0 too except in the status register
    always_comb
    begin
        readValue = '0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (targetSel[i])
            begin
                readValue[ADDR_FIELD_MSB:ADDR_FIELD_LSB] = st_reg.target[i];
            end
            if (aliasSel[i])
            begin
                readValue[ADDR_FIELD_MSB:ADDR_FIELD_LSB] = st_reg.aliasAddr[i];
            end
        end
        if ((address[1:0] == 2'h0) && (regIdx == STATUS_IDX))
        begin
            readValue[STAT_HIT_BIT] = st_reg.lastHit;
            readValue[STAT_ENTRY_LSB +: ENTRY_W] = st_reg.lastEntry;
            readValue[STAT_CNT_LSB +: STAT_CNT_W] = st_reg.fwdCount;
        end
    end

    always_comb
    begin
        st_next = st_reg;
        // every access answers one cycle after it is first seen
        st_next.waitReq = !(busReq && st_reg.waitReq);
        if (busReq && st_reg.waitReq)
        begin
            st_next.rdata = readValue;
        end
        if (write && !st_reg.waitReq && byteenable[0])
        begin
            for (int i = 0; i < ENTRIES; i++)
            begin
                if (targetSel[i])
                begin
                    st_next.target[i] = writedata[ADDR_FIELD_MSB:ADDR_FIELD_LSB];
                end
                if (aliasSel[i])
                begin
                    st_next.aliasAddr[i] = writedata[ADDR_FIELD_MSB:ADDR_FIELD_LSB];
                end
            end
        end
        st_next.fwdValid = 1'b0;
        st_next.missValid = 1'b0;
        if (reqValid)
        begin
            if (anyHit)
            begin
                st_next.fwdValid = 1'b1;
                st_next.fwdAddr = st_reg.target[hitIdx];
                st_next.fwdRnw = reqRnw;
                st_next.fwdEntry = hitIdx;
                st_next.lastHit = 1'b1;
                st_next.lastEntry = hitIdx;
                st_next.fwdCount = st_reg.fwdCount + STAT_CNT_W'(1);
            end
            else
            begin
                // not ours: the local bus carries on without the remote link
                st_next.missValid = 1'b1;
                st_next.lastHit = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_reg <= STATE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign readdata = st_reg.rdata;
    assign waitrequest = st_reg.waitReq;
    assign fwdValid = st_reg.fwdValid;
    assign fwdAddr = st_reg.fwdAddr;
    assign fwdRnw = st_reg.fwdRnw;
    assign fwdEntry = st_reg.fwdEntry;
    assign missValid = st_reg.missValid;

    // helper copies for the pairing checks
    logic [ENTRIES-1:0][I2C_ADDR_W-1:0] prevTarget;
    logic [ENTRIES-1:0][I2C_ADDR_W-1:0] prevAlias;
    always_ff @(posedge clk)
    begin
        prevTarget <= st_reg.target;
        prevAlias <= st_reg.aliasAddr;
    end

    chk_target_write: assert property (@(posedge clk) disable iff (reset)
        (write && !waitrequest && byteenable[0] && targetSel[0]) |=> (st_reg.target[0] == $past(writedata[7:1])))
        else $error("target entry write not stored");
    chk_alias_write: assert property (@(posedge clk) disable iff (reset)
        (write && !waitrequest && byteenable[0] && aliasSel[0]) |=> (st_reg.aliasAddr[0] == $past(writedata[7:1])))
        else $error("alias entry write not stored");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        (read && !waitrequest) |-> (readdata[31:8] == 24'h000000 && (readdata[0] == 1'b0 || regIdx == STATUS_IDX)))
        else $error("reserved read bits not zero");
    chk_remap_hit: assert property (@(posedge clk) disable iff (reset)
        (reqValid && anyHit) |=> (fwdValid && fwdAddr == $past(st_reg.target[hitIdx]) && !missValid))
        else $error("alias hit not remapped next cycle");
    chk_pair_index: assert property (@(posedge clk) disable iff (reset)
        fwdValid |-> (fwdAddr == prevTarget[fwdEntry] && prevAlias[fwdEntry] == $past(reqAddr)))
        else $error("forwarded address not from paired entry");
    chk_zero_alias_off: assert property (@(posedge clk) disable iff (reset)
        (reqValid && reqAddr == 7'h00) |=> (!fwdValid && missValid))
        else $error("zero address forwarded through disabled alias");
    chk_forward_miss: assert property (@(posedge clk) disable iff (reset)
        (reqValid && !anyHit) |=> (missValid && !fwdValid) ##1 !missValid || $past(reqValid))
        else $error("miss handling wrong");
    chk_reset_clear: assert property (@(posedge clk) disable iff (reset)
        $past(reset) |-> (st_reg.target == '0 && st_reg.aliasAddr == '0 && !fwdValid))
        else $error("registers not zero after reset");
    chk_bus_answer: assert property (@(posedge clk) disable iff (reset)
        (busReq && waitrequest) |=> (!waitrequest ##1 waitrequest))
        else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// *** tb/remote_link_model.sv ***
// model of the control channel receiver behind the remap block
`default_nettype none
module remote_link_model
    import remote_i2c_alias_remap_pkg::*;
(
    input wire logic clk,
    input wire logic fwdValid,
    input wire logic [remote_i2c_alias_remap_pkg::I2C_ADDR_W-1:0] fwdAddr,
    input wire logic fwdRnw,
    output logic [7:0] lastSeen,
    output int fwdCount
);
    timeunit 1ns;
    timeprecision 1ps;
    // keeps the address and direction byte as the remote side would receive it
    initial
    begin
        lastSeen = 8'h00;
        fwdCount = 0;
        forever
        begin
            @(posedge clk);
            if (fwdValid === 1'b1)
            begin
                lastSeen <= {fwdAddr, fwdRnw};
                fwdCount <= fwdCount + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// register and remap tests for the alias remapping block
`default_nettype none
module testbench
    import remote_i2c_alias_remap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, read, write, waitrequest, reqValid, reqRnw, fwdValid, fwdRnw, missValid;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [6:0] reqAddr, fwdAddr;
    logic [2:0] fwdEntry;
    logic [7:0] lastSeen;
    logic [3:0] byteEn;
    int fwdCount, error_cnt = 0, n_tests = 0;
    int ents[5] = '{1, 2, 3, 6, 7};
    remote_i2c_alias_remap #(.ENTRIES(NUM_ENTRIES)) dut_u (.clk(clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteEn), .readdata(readdata),
        .waitrequest(waitrequest), .reqValid(reqValid), .reqAddr(reqAddr), .reqRnw(reqRnw),
        .fwdValid(fwdValid), .fwdAddr(fwdAddr), .fwdRnw(fwdRnw), .fwdEntry(fwdEntry), .missValid(missValid));
    remote_link_model link_u (.clk(clk), .fwdValid(fwdValid), .fwdAddr(fwdAddr), .fwdRnw(fwdRnw),
        .lastSeen(lastSeen), .fwdCount(fwdCount));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // holds the request until the edge where waitrequest is seen low
    task automatic bus(input logic wr, input int idx, input logic [31:0] data);
        @(posedge clk);
        write <= wr;
        read <= !wr;
        address <= 10'(idx * 4);
        writedata <= data;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic sendReq(input logic [6:0] a, input logic hit, input logic [6:0] ea, input int ee);
        @(posedge clk);
        reqValid <= 1'b1;
        reqAddr <= a;
        reqRnw <= a[0];
        @(posedge clk);
        reqValid <= 1'b0;
        @(negedge clk);
        check("fwdValid", fwdValid, hit);
        check("missValid", missValid, !hit);
        if (hit)
        begin
            check("fwdAddr", fwdAddr, ea);
            check("fwdEntry", fwdEntry, 32'(ee));
            check("fwdRnw", fwdRnw, a[0]);
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    initial
    begin
        {reset, read, write, reqValid, reqRnw, address, writedata, reqAddr} = '0;
        byteEn = 4'hF;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        foreach (ents[i])
        begin
            bus(1'b0, TARGET_BASE_IDX + ents[i] - 1, 0);
            check("target reset", rd, 0);
            bus(1'b0, ALIAS_BASE_IDX + ents[i] - 1, 0);
            check("alias reset", rd, 0);
        end
        sendReq(7'h00, 1'b0, 0, 0);
        $display("reset test done");
        // bit 0 and upper bytes are set on purpose; they must not stick
        foreach (ents[i])
        begin
            bus(1'b1, TARGET_BASE_IDX + ents[i] - 1, {24'hFFFFFF, 7'(32 + ents[i]), 1'b1});
            bus(1'b1, ALIAS_BASE_IDX + ents[i] - 1, {24'hFFFFFF, 7'(80 + ents[i]), 1'b1});
            bus(1'b0, TARGET_BASE_IDX + ents[i] - 1, 0);
            check("target field", rd, {24'h0, 7'(32 + ents[i]), 1'b0});
            bus(1'b0, ALIAS_BASE_IDX + ents[i] - 1, 0);
            check("alias field", rd, {24'h0, 7'(80 + ents[i]), 1'b0});
        end
        $display("register test done");
        foreach (ents[i])
            sendReq(7'(80 + ents[i]), 1'b1, 7'(32 + ents[i]), ents[i] - 1);
        sendReq(7'h7F, 1'b0, 0, 0);
        @(posedge clk);
        check("link count", fwdCount, 5);
        check("link byte", lastSeen, {7'(39), 1'b1});
        bus(1'b0, STATUS_IDX, 0);
        check("status", rd, {24'h0, 4'(5), 3'(6), 1'b0});
        $display("remap test done");
        bus(1'b1, ALIAS_2_IDX, 0);
        sendReq(7'(82), 1'b0, 0, 0);
        // alias 3 now shadows alias 1, so the lower entry must still win
        bus(1'b1, ALIAS_3_IDX, {24'h0, 7'(81), 1'b0});
        sendReq(7'(81), 1'b1, 7'(33), 0);
        bus(1'b0, 255, 0);
        check("unmapped read", rd, 0);
        $display("disable test done");
        // a write with lane 0 off must leave the field alone
        byteEn <= 4'hE;
        bus(1'b1, TARGET_7_IDX, {24'h0, 7'h55, 1'b0});
        byteEn <= 4'hF;
        bus(1'b0, TARGET_7_IDX, 0);
        check("lane off write", rd, {24'h0, 7'(39), 1'b0});
        $display("lane test done");
        // second reset with programmed entries must clear everything again
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, TARGET_7_IDX, 0);
        check("target after reset", rd, 0);
        bus(1'b0, ALIAS_1_IDX, 0);
        check("alias after reset", rd, 0);
        bus(1'b0, STATUS_IDX, 0);
        check("status after reset", rd, 0);
        sendReq(7'(81), 1'b0, 0, 0);
        $display("second reset test done");
        conclude();
    end
endmodule
`default_nettype wire
